/* shared/wsol_consts.svh */
/*
 * Constants of the welder status output block: register offsets, field
 * positions, reset values and timing figures.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef WSOL_CONSTS_SVH
`define WSOL_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define WSOL_OFS_CTRL     8'h00
`define WSOL_OFS_LIMIT_HI 8'h04
`define WSOL_OFS_LIMIT_LO 8'h08
`define WSOL_OFS_HOLDOFF  8'h0C
`define WSOL_OFS_STATUS   8'h10
`define WSOL_OFS_ERROR    8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define WSOL_CTRL_REPEAT  0
`define WSOL_CTRL_FRESET  1

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define WSOL_RST_LIMIT_HI 16'hFFFF
`define WSOL_RST_LIMIT_LO 16'h0000
`define WSOL_RST_HOLDOFF  16'h0064
`define WSOL_ERR_POWER    8'h23

// ****************************************************************
// Timing
// ****************************************************************
`define WSOL_CLK_NS       50
`define WSOL_TICK_NS      1000000
`define WSOL_TICK_CYC     (`WSOL_TICK_NS / `WSOL_CLK_NS)
`define WSOL_PULSE_MS     20
`define WSOL_PULSE_TICKS  (`WSOL_PULSE_MS * `WSOL_TICK_NS / 1000000)

`endif

/* shared/wsol_pkg.sv */
/*
 * Types of the welder status output block.
 * Assumes wsol_consts.svh is on the include path.
 */
`default_nettype none

package wsol_pkg;
	`include "wsol_consts.svh"

	// ****************************************************************
	// Fault state machine
	// ****************************************************************
	typedef enum logic [2:0] {
		WSOL_HEALTHY  = 3'h1,
		WSOL_FAULTED  = 3'h2,
		WSOL_CLEARING = 3'h4
	} wsol_fault_t;
endpackage : wsol_pkg

`default_nettype wire

/* logic/wsol_pulse_timer.sv */
/*
 * Fixed-width pulse timer counted in timebase ticks.
 * Assumes a one-cycle tick strobe from the parent and a shared clock enable.
 */
`timescale 1ns/100ps
`default_nettype none

module wsol_pulse_timer #(
	parameter int W     = 8,
	parameter int TICKS = 20
) (
	// Clock, reset and enable
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Timing
	input  wire logic tick,
	input  wire logic trigger,
	// Pulse
	output var  logic active
);
	localparam logic [W-1:0] LOAD = W'(TICKS);

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_active;

	// ****************************************************************
	// Countdown from the trigger, one step per tick
	// ****************************************************************
	always_comb begin
		next_cnt    = cnt;
		next_active = active;
		if (trigger) begin
			next_cnt    = LOAD;
			next_active = 1'b1;
		end else if (tick && active) begin
			next_cnt    = cnt - W'(1);
			next_active = (cnt != W'(1));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt    <= '0;
			active <= 1'b0;
		end else if (ce) begin
			cnt    <= next_cnt;
			active <= next_active;
		end
	end
endmodule : wsol_pulse_timer

`default_nettype wire

/* logic/wsol_status_out.sv */
/*
 * Contact status outputs of the welder external I/O connector with an
 * APB register slave for monitor limits, hold-off and status.
 * Assumes device inputs are synchronous to pclk; outputs are 1 = contact closed.
 */
// Local design decisions: the register offsets and register access over APB.
// Operation
// RULE1 - Diode status contact closed exactly while pump diode is energised.
// RULE2 - Aiming beam contact closed exactly while the aiming beam emits.
// RULE3 - Ready closes only when emission possible and valid schedule selected.
// RULE4 - Repeat mode drops ready for the hold-off time after each emission.
// RULE5 - Any fault opens the fault contact until a fault reset is accepted.
// RULE6 - Emission contact closed during emission; controller uses it for indication only.
// RULE7 - Shot energy within limits gives a 20 ms monitor-normal pulse.
// RULE8 - Energy out of limits gives 20 ms monitor-fault pulse and power range error.
// RULE9 - Each completed emission gives one 20 ms shot-complete pulse.
// RULE10 - External-accepted contact follows the external control select input.
// RULE11 - External commands are ignored while external-accepted contact is open.
// RULE12 - Controller closes select input; external inputs honoured only while closed.
// RULE13 - Accepted fault reset cancels the alarm once the cause is gone.
// RULE14 - Pulse widths are counted in internal timebase ticks from the event.
// RULE15 - Each monitored shot gives exactly one of normal or fault pulse.
`timescale 1ns/100ps
`default_nettype none
`include "wsol_consts.svh"

module wsol_status_out #(
	parameter int TICK_CYC = `WSOL_TICK_CYC,
	parameter int EW       = 16,
	parameter int NCMD     = 4
) (
	// Clock, reset and enable
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            ce,
	// APB slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output var  logic [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Device state
	input  wire logic            pump_diode_on,
	input  wire logic            aim_beam_on,
	input  wire logic            emission_on,
	input  wire logic            emission_possible,
	input  wire logic            schedule_valid,
	input  wire logic            fault_event,
	input  wire logic            fault_cause,
	input  wire logic            shot_measured,
	input  wire logic [EW-1:0]   shot_energy,
	// External inputs
	input  wire logic            external_control_select,
	input  wire logic            ext_fault_reset,
	input  wire logic [NCMD-1:0] ext_cmd_in,
	// Contacts and gated commands
	output var  logic            diode_energised_status,
	output var  logic            aim_beam_status,
	output var  logic            ready_status,
	output var  logic            fault_ok_status,
	output var  logic            emission_status,
	output logic                 monitor_normal_status,
	output logic                 monitor_fault_status,
	output logic                 shot_done_status,
	output var  logic            ext_accept_status,
	output var  logic [NCMD-1:0] ext_cmd_out,
	output var  logic            power_range_error
);
	localparam int TW = $clog2(TICK_CYC + 1);

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic                 repeat_mode, next_repeat_mode;
	logic [15:0]          limit_hi, next_limit_hi;
	logic [15:0]          limit_lo, next_limit_lo;
	logic [15:0]          holdoff, next_holdoff;
	logic                 sw_freset, next_sw_freset;
	logic [31:0]          next_prdata;
	logic [TW-1:0]        pre_cnt, next_pre_cnt;
	logic                 tick, next_tick;
	logic [15:0]          hold_cnt, next_hold_cnt;
	logic                 emis_q, next_emis_q;
	logic                 next_power_err;
	logic [NCMD-1:0]      next_ext_cmd;
	wsol_pkg::wsol_fault_t fstate, next_fstate;
	logic                 next_diode, next_aim, next_ready, next_emis, next_accept;
	logic                 setup_ph, wr_en, mapped;
	logic                 shot_end, mon_good, mon_bad, reset_req;
	logic [2:0]           trig, pulse;

	function automatic logic in_limits(input logic [EW-1:0] e, input logic [15:0] hi,
					   input logic [15:0] lo);
		in_limits = (16'(e) <= hi) && (16'(e) >= lo);
	endfunction : in_limits

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `WSOL_OFS_CTRL) || (a == `WSOL_OFS_LIMIT_HI) ||
			    (a == `WSOL_OFS_LIMIT_LO) || (a == `WSOL_OFS_HOLDOFF) ||
			    (a == `WSOL_OFS_STATUS) || (a == `WSOL_OFS_ERROR);
	endfunction : is_mapped

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign setup_ph = psel && !penable;
	assign mapped   = is_mapped(paddr);
	assign pready   = ce;
	assign pslverr  = psel && penable && !mapped;
	assign wr_en    = ce && psel && penable && pwrite;

	always_comb begin
		next_repeat_mode = repeat_mode;
		next_limit_hi    = limit_hi;
		next_limit_lo    = limit_lo;
		next_holdoff     = holdoff;
		next_sw_freset   = 1'b0;
		next_prdata      = prdata;
		if (wr_en) begin
			case (paddr)
				`WSOL_OFS_CTRL: begin
					next_repeat_mode = pwdata[`WSOL_CTRL_REPEAT];
					next_sw_freset   = pwdata[`WSOL_CTRL_FRESET];
				end
				`WSOL_OFS_LIMIT_HI: next_limit_hi = pwdata[15:0];
				`WSOL_OFS_LIMIT_LO: next_limit_lo = pwdata[15:0];
				`WSOL_OFS_HOLDOFF:  next_holdoff  = pwdata[15:0];
				default: ;
			endcase
		end
		if (setup_ph && !pwrite) begin
			case (paddr)
				`WSOL_OFS_CTRL:     next_prdata = {31'h0, repeat_mode};
				`WSOL_OFS_LIMIT_HI: next_prdata = {16'h0, limit_hi};
				`WSOL_OFS_LIMIT_LO: next_prdata = {16'h0, limit_lo};
				`WSOL_OFS_HOLDOFF:  next_prdata = {16'h0, holdoff};
				`WSOL_OFS_STATUS:   next_prdata = {20'h0, fstate != wsol_pkg::WSOL_HEALTHY,
					ext_accept_status, shot_done_status, monitor_fault_status,
					monitor_normal_status, emission_status, fault_ok_status,
					ready_status, aim_beam_status, diode_energised_status,
					hold_cnt != 16'h0000, emis_q};
				`WSOL_OFS_ERROR:    next_prdata = power_range_error ?
					{24'h0, `WSOL_ERR_POWER} : 32'h0000_0000;
				default:            next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			repeat_mode <= 1'b0;
			limit_hi    <= `WSOL_RST_LIMIT_HI;
			limit_lo    <= `WSOL_RST_LIMIT_LO;
			holdoff     <= `WSOL_RST_HOLDOFF;
			sw_freset   <= 1'b0;
			prdata      <= 32'h0000_0000;
		end else if (ce) begin
			repeat_mode <= next_repeat_mode;
			limit_hi    <= next_limit_hi;
			limit_lo    <= next_limit_lo;
			holdoff     <= next_holdoff;
			sw_freset   <= next_sw_freset;
			prdata      <= next_prdata;
		end
	end

	// ****************************************************************
	// Timebase, emission edge and hold-off
	// ****************************************************************
	assign shot_end = emis_q && !emission_on;

	always_comb begin
		next_tick    = (pre_cnt == TW'(TICK_CYC - 1));
		next_pre_cnt = next_tick ? '0 : pre_cnt + TW'(1); // RULE14
		next_emis_q  = emission_on;
		next_hold_cnt = hold_cnt;
		if (shot_end)
			next_hold_cnt = holdoff; // RULE4
		else if (tick && hold_cnt != 16'h0000)
			next_hold_cnt = hold_cnt - 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt  <= '0;
			tick     <= 1'b0;
			emis_q   <= 1'b0;
			hold_cnt <= 16'h0000;
		end else if (ce) begin
			pre_cnt  <= next_pre_cnt;
			tick     <= next_tick;
			emis_q   <= next_emis_q;
			hold_cnt <= next_hold_cnt;
		end
	end

	// ****************************************************************
	// Fault state and power range error
	// ****************************************************************
	assign mon_good  = shot_measured && in_limits(shot_energy, limit_hi, limit_lo); // RULE15
	assign mon_bad   = shot_measured && !in_limits(shot_energy, limit_hi, limit_lo);
	assign reset_req = ((ext_accept_status && ext_fault_reset) || sw_freset) && !fault_cause;

	always_comb begin
		next_fstate    = fstate;
		next_power_err = power_range_error || mon_bad; // RULE8
		case (fstate)
			wsol_pkg::WSOL_HEALTHY:  if (fault_event || mon_bad)
				next_fstate = wsol_pkg::WSOL_FAULTED; // RULE5
			wsol_pkg::WSOL_FAULTED:  if (reset_req && !fault_event)
				next_fstate = wsol_pkg::WSOL_CLEARING; // RULE13
			wsol_pkg::WSOL_CLEARING: begin
				if (fault_event || mon_bad || fault_cause)
					next_fstate = wsol_pkg::WSOL_FAULTED;
				else if (tick) begin
					next_fstate    = wsol_pkg::WSOL_HEALTHY; // RULE13
					next_power_err = 1'b0;
				end
			end
			default: next_fstate = wsol_pkg::WSOL_FAULTED;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fstate            <= wsol_pkg::WSOL_HEALTHY;
			power_range_error <= 1'b0;
		end else if (ce) begin
			fstate            <= next_fstate;
			power_range_error <= next_power_err;
		end
	end

	// ****************************************************************
	// Level contacts and external command gate
	// ****************************************************************
	always_comb begin
		next_diode   = pump_diode_on; // RULE1
		next_aim     = aim_beam_on; // RULE2
		next_emis    = emission_on; // RULE6
		next_accept  = external_control_select; // RULE10 RULE12
		next_ready   = emission_possible && schedule_valid && // RULE3
			       (fstate == wsol_pkg::WSOL_HEALTHY) &&
			       !(repeat_mode && (hold_cnt != 16'h0000)); // RULE4
		next_ext_cmd = ext_accept_status ? ext_cmd_in : '0; // RULE11
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diode_energised_status <= 1'b0;
			aim_beam_status        <= 1'b0;
			emission_status        <= 1'b0;
			ext_accept_status      <= 1'b0;
			ready_status           <= 1'b0;
			fault_ok_status        <= 1'b1;
			ext_cmd_out            <= '0;
		end else if (ce) begin
			diode_energised_status <= next_diode;
			aim_beam_status        <= next_aim;
			emission_status        <= next_emis;
			ext_accept_status      <= next_accept;
			ready_status           <= next_ready;
			fault_ok_status        <= (next_fstate == wsol_pkg::WSOL_HEALTHY); // RULE5
			ext_cmd_out            <= next_ext_cmd;
		end
	end

	// ****************************************************************
	// Fixed 20 ms pulses
	// ****************************************************************
	assign trig = {shot_end, mon_bad, mon_good};

	generate
		for (genvar i = 0; i < 3; i++) begin : g_pulse
			wsol_pulse_timer #(
				.W     (8),
				.TICKS (`WSOL_PULSE_TICKS + 1)
			) u_timer (
				.pclk    (pclk),
				.presetn (presetn),
				.ce      (ce),
				.tick    (tick),
				.trigger (trig[i]), // RULE14
				.active  (pulse[i])
			);
		end
	endgenerate

	assign monitor_normal_status = pulse[0] && !pulse[1]; // RULE7 RULE15
	assign monitor_fault_status  = pulse[1]; // RULE8
	assign shot_done_status      = pulse[2]; // RULE9

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_shot_ends;
		ce && emis_q && !emission_on;
	endsequence

	a_diode_follow: assert property (ce |=> diode_energised_status == $past(pump_diode_on)) // RULE1
		else $error("Diode contact does not follow diode.");
	a_aim_follow: assert property (ce |=> aim_beam_status == $past(aim_beam_on)) // RULE2
		else $error("Aim contact does not follow beam.");
	a_ready_gate: assert property (ce |=> !ready_status || $past(emission_possible && schedule_valid)) // RULE3
		else $error("Ready without emission possible and schedule.");
	a_ready_holdoff: assert property (s_shot_ends ##1 (ce && repeat_mode && holdoff != 16'h0000)
					  |=> !ready_status) // RULE4
		else $error("Ready during repeat hold-off.");
	a_fault_opens: assert property (ce && fault_event |=> !fault_ok_status) // RULE5
		else $error("Fault contact stayed closed on fault.");
	a_emis_follow: assert property (ce |=> emission_status == $past(emission_on)) // RULE6
		else $error("Emission contact does not follow emission.");
	a_mon_exclusive: assert property (ce && shot_measured |=> monitor_normal_status != monitor_fault_status) // RULE15
		else $error("Not exactly one monitor pulse after shot.");
	a_bad_raises_err: assert property (ce && mon_bad |=> power_range_error && monitor_fault_status) // RULE8
		else $error("Out of range shot without error and pulse.");
	a_shot_pulse: assert property (s_shot_ends |=> shot_done_status) // RULE9
		else $error("No shot complete pulse after emission.");
	a_cmd_gated: assert property (ce && !ext_accept_status |=> ext_cmd_out == '0) // RULE11
		else $error("External command passed while not accepted.");
endmodule : wsol_status_out

`default_nettype wire

/* dv/wsol_controller.sv */
/*
 * External controller model: drives the select, fault reset and command lines.
 * Assumes the bench supplies pclk and calls the tasks from its own process.
 */
`timescale 1ns/100ps
`default_nettype none

module wsol_controller (
	// Clock
	input  wire logic       pclk,
	// Device contact
	input  wire logic       fault_ok_status,
	// Controller lines
	output var  logic       external_control_select,
	output var  logic       ext_fault_reset,
	output var  logic [3:0] ext_cmd_in
);
	// The emission contact is not wired in, as it is no timing source.
	initial begin
		external_control_select = 1'b0;
		ext_fault_reset = 1'b0;
		ext_cmd_in = 4'h0;
	end

	task automatic set_select(input logic v);
		@(posedge pclk) external_control_select <= v;
	endtask : set_select

	task automatic set_cmd(input logic [3:0] v);
		@(posedge pclk) ext_cmd_in <= v;
	endtask : set_cmd

	// Holds the fault reset closed for up to n cycles, less once the contact closes.
	task automatic press_reset(input int n);
		@(posedge pclk) ext_fault_reset <= 1'b1;
		for (int i = 0; i < n && fault_ok_status !== 1'b1; i++) @(posedge pclk);
		ext_fault_reset <= 1'b0;
	endtask : press_reset
endmodule : wsol_controller

`default_nettype wire

/* dv/wsol_status_out_test.sv */
/*
 * Self-checking bench of the welder status outputs with an APB master.
 * Assumes the design files, the package and wsol_consts.svh are compiled.
 */
`timescale 1ns/100ps
`default_nettype none
`include "wsol_consts.svh"

module wsol_status_out_test;
	localparam int TC = 10;
	localparam int PW = `WSOL_PULSE_MS * TC;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic pump_diode_on = 1'b0, aim_beam_on = 1'b0, emission_on = 1'b0;
	logic emission_possible = 1'b0, schedule_valid = 1'b0, erv;
	logic fault_event = 1'b0, fault_cause = 1'b0, shot_measured = 1'b0;
	logic [15:0] shot_energy = 16'h0000;
	logic external_control_select, ext_fault_reset;
	logic [3:0] ext_cmd_in, ext_cmd_out;
	logic diode_energised_status, aim_beam_status, ready_status, fault_ok_status;
	logic emission_status, monitor_normal_status, monitor_fault_status;
	logic shot_done_status, ext_accept_status, power_range_error;
	int error_cnt = 0, compares = 0;

	always #25 pclk = ~pclk;

	wsol_status_out #(.TICK_CYC(TC)) i_dut (.pclk, .presetn, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pump_diode_on,
		.aim_beam_on, .emission_on, .emission_possible, .schedule_valid,
		.fault_event, .fault_cause, .shot_measured, .shot_energy,
		.external_control_select, .ext_fault_reset, .ext_cmd_in,
		.diode_energised_status, .aim_beam_status, .ready_status, .fault_ok_status,
		.emission_status, .monitor_normal_status, .monitor_fault_status,
		.shot_done_status, .ext_accept_status, .ext_cmd_out, .power_range_error);

	wsol_controller i_ctl (.pclk, .fault_ok_status, .external_control_select,
		.ext_fault_reset, .ext_cmd_in);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	task automatic chk1(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask : chk1

	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk32

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			conclude();
		end
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic pulse(input int s);
		return s == 0 ? monitor_normal_status : s == 1 ? monitor_fault_status : shot_done_status;
	endfunction : pulse

	task automatic pulse_chk(input int s);
		int w;
		logic o;
		w = 0;
		o = 1'b0;
		#1;
		for (int i = 0; i < 5 && pulse(s) !== 1'b1; i++) cyc(1);
		while (pulse(s) === 1'b1 && w < 400) begin
			if (s < 2 && pulse(1 - s) === 1'b1) o = 1'b1;
			w++;
			cyc(1);
		end
		chk1("pulse width", 1'b1, w >= PW && w <= PW + TC);
		chk1("other pulse", 1'b0, o);
	endtask : pulse_chk

	task automatic shot(input logic [15:0] v);
		@(posedge pclk);
		shot_measured <= 1'b1;
		shot_energy <= v;
		@(posedge pclk);
		shot_measured <= 1'b0;
	endtask : shot

	task automatic wait_ok(input int n);
		for (int i = 0; i < n && fault_ok_status !== 1'b1; i++) cyc(1);
	endtask : wait_ok

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_regs();
		apb(1'b0, `WSOL_OFS_LIMIT_HI, 32'h0);
		chk32("limit_hi", {16'h0000, `WSOL_RST_LIMIT_HI}, rdv);
		apb(1'b0, `WSOL_OFS_LIMIT_LO, 32'h0);
		chk32("limit_lo", {16'h0000, `WSOL_RST_LIMIT_LO}, rdv);
		apb(1'b0, `WSOL_OFS_HOLDOFF, 32'h0);
		chk32("holdoff", {16'h0000, `WSOL_RST_HOLDOFF}, rdv);
		apb(1'b0, `WSOL_OFS_ERROR, 32'h0);
		chk32("error", 32'h0, rdv);
		apb(1'b0, `WSOL_OFS_STATUS, 32'h0);
		chk1("status fault_ok", 1'b1, rdv[5]);
		apb(1'b1, 8'h20, 32'hFFFFFFFF);
		chk1("unmapped wr err", 1'b1, erv);
		apb(1'b0, 8'h20, 32'h0);
		chk1("unmapped rd err", 1'b1, erv);
		chk32("unmapped rd", 32'h0, rdv);
	endtask : t_regs

	task automatic t_levels();
		apb(1'b1, `WSOL_OFS_HOLDOFF, 32'h3);
		for (int p = 0; p < 8; p++) begin
			@(posedge pclk);
			{pump_diode_on, aim_beam_on, emission_on} <= p[2:0];
			cyc(1);
			chk1("diode", p[2], diode_energised_status);
			chk1("aim", p[1], aim_beam_status);
			chk1("emission", p[0], emission_status);
		end
		@(posedge pclk);
		{pump_diode_on, aim_beam_on, emission_on} <= 3'h0;
	endtask : t_levels

	task automatic t_ready();
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			{emission_possible, schedule_valid} <= i[1:0];
			cyc(2);
			chk1("ready", i == 3, ready_status);
		end
	endtask : t_ready

	task automatic t_ext();
		i_ctl.set_cmd(4'hF);
		cyc(3);
		chk1("accept off", 1'b0, ext_accept_status);
		chk32("cmd gated", 32'h0, {28'h0, ext_cmd_out});
		i_ctl.set_select(1'b1);
		cyc(3);
		chk1("accept on", 1'b1, ext_accept_status);
		chk32("cmd pass", 32'hF, {28'h0, ext_cmd_out});
		i_ctl.set_cmd(4'h5);
		cyc(3);
		chk32("cmd pass 5", 32'h5, {28'h0, ext_cmd_out});
		i_ctl.set_select(1'b0);
		cyc(3);
		chk32("cmd dropped", 32'h0, {28'h0, ext_cmd_out});
	endtask : t_ext

	task automatic t_monitor();
		apb(1'b1, `WSOL_OFS_LIMIT_LO, 32'h100);
		apb(1'b1, `WSOL_OFS_LIMIT_HI, 32'h200);
		shot(16'h0100);
		pulse_chk(0);
		shot(16'h0200);
		pulse_chk(0);
		shot(16'h0201);
		#1;
		chk1("mon fault", 1'b1, monitor_fault_status);
		chk1("power err", 1'b1, power_range_error);
		chk1("fault open", 1'b0, fault_ok_status);
		pulse_chk(1);
		apb(1'b0, `WSOL_OFS_ERROR, 32'h0);
		chk32("error code", {24'h0, `WSOL_ERR_POWER}, rdv);
		chk1("ready faulted", 1'b0, ready_status);
		apb(1'b1, `WSOL_OFS_CTRL, 32'h2);
		wait_ok(TC + 3);
		chk1("sw reset", 1'b1, fault_ok_status);
		chk1("power err clr", 1'b0, power_range_error);
	endtask : t_monitor

	task automatic t_fault();
		@(posedge pclk);
		fault_event <= 1'b1;
		fault_cause <= 1'b1;
		@(posedge pclk);
		fault_event <= 1'b0;
		cyc(1);
		chk1("fault open", 1'b0, fault_ok_status);
		i_ctl.set_select(1'b1);
		i_ctl.press_reset(3 * TC);
		cyc(1);
		chk1("cause held", 1'b0, fault_ok_status);
		@(posedge pclk);
		fault_cause <= 1'b0;
		i_ctl.set_select(1'b0);
		cyc(2);
		i_ctl.press_reset(3 * TC);
		cyc(1);
		chk1("reset ignored", 1'b0, fault_ok_status);
		i_ctl.set_select(1'b1);
		cyc(2);
		i_ctl.press_reset(TC + 4);
		wait_ok(2);
		chk1("ext reset", 1'b1, fault_ok_status);
	endtask : t_fault

	task automatic t_holdoff();
		apb(1'b1, `WSOL_OFS_HOLDOFF, 32'h3);
		apb(1'b1, `WSOL_OFS_CTRL, 32'h1);
		cyc(2);
		chk1("ready before", 1'b1, ready_status);
		@(posedge pclk);
		emission_on <= 1'b1;
		cyc(3);
		@(posedge pclk);
		emission_on <= 1'b0;
		cyc(2 * TC);
		chk1("ready holdoff", 1'b0, ready_status);
		cyc(2 * TC + 5);
		chk1("ready back", 1'b1, ready_status);
		apb(1'b1, `WSOL_OFS_CTRL, 32'h0);
	endtask : t_holdoff

	task automatic t_shot();
		cyc(PW + TC);
		@(posedge pclk);
		emission_on <= 1'b1;
		cyc(2);
		@(posedge pclk);
		emission_on <= 1'b0;
		pulse_chk(2);
		chk1("ready no hold", 1'b1, ready_status);
		cyc(5 * TC);
		chk1("single pulse", 1'b0, shot_done_status);
	endtask : t_shot

	task automatic t_freeze();
		@(posedge pclk);
		ce <= 1'b0;
		pump_diode_on <= 1'b1;
		cyc(2);
		chk1("pready frozen", 1'b0, pready);
		chk1("diode frozen", 1'b0, diode_energised_status);
		@(posedge pclk);
		ce <= 1'b1;
		cyc(1);
		chk1("diode resumed", 1'b1, diode_energised_status);
		apb(1'b1, `WSOL_OFS_LIMIT_HI, 32'h1234);
		@(posedge pclk);
		presetn <= 1'b0;
		pump_diode_on <= 1'b0;
		cyc(1);
		chk1("reset fault_ok", 1'b1, fault_ok_status);
		chk1("reset ready", 1'b0, ready_status);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `WSOL_OFS_LIMIT_HI, 32'h0);
		chk32("limit_hi reset", {16'h0000, `WSOL_RST_LIMIT_HI}, rdv);
		chk1("ready after reset", 1'b1, ready_status);
	endtask : t_freeze

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_levels();
		t_ready();
		t_ext();
		t_monitor();
		t_fault();
		t_holdoff();
		t_shot();
		t_freeze();
		conclude();
	end
endmodule : wsol_status_out_test

`default_nettype wire
